// >>> src/prl_pkg.sv
package prl_pkg;
  // ports: 0 = first port, 1 = second, 2 = third; 8 pins each (unimplemented pins tie low)
  localparam int unsigned N_PORTS      = 3;
  localparam int unsigned N_PINS       = 24;
  localparam int unsigned N_IN_SEL     = 8;
  localparam int unsigned N_SRC        = 36;
  localparam int unsigned SEL_W        = 6;
  localparam int unsigned OSRC_W       = 6;
  localparam int unsigned DATA_W       = 8;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;
  localparam int unsigned LOCK_BIT_POS = 0;
  localparam logic [5:0]  OSRC_RESET   = 6'h00;
  localparam logic [5:0]  OSRC_LATCH   = 6'h00;
  localparam logic [5:0]  OSRC_MAX     = 6'h23;
  // valid output source codes; clear bits mark reserved codes
  localparam logic [N_SRC-1:0] OSRC_VALID = 36'hF_FFF8_7FFF & ~(36'h1 << 20) & ~(36'h1 << 23);
  // input select defaults {port[2:0], pin[2:0]}: index 0 is the external interrupt input
  localparam logic [SEL_W-1:0] IN_SEL_RESET [N_IN_SEL] = '{
    6'h02, 6'h02, 6'h05, 6'h04, 6'h15, 6'h14, 6'h05, 6'h11
  };
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_ARMED = 2'b10
  } prl_key_t;
endpackage : prl_pkg

// >>> src/prl_in_mux.sv
`timescale 1ns/100ps
`default_nettype none
module prl_in_mux (
  input  wire logic [prl_pkg::N_PINS-1:0] pin_level_i,
  input  wire logic [prl_pkg::SEL_W-1:0]  sel_i,
  output logic                            level_o
);
  import prl_pkg::*;
  always_comb begin
    level_o = 1'b0;
    if (sel_i[5:3] < 3'(N_PORTS)) begin
      level_o = pin_level_i[{sel_i[4:3], sel_i[2:0]}];
    end
  end
endmodule : prl_in_mux
`default_nettype wire

// >>> src/prl_routing_lock.sv
// Summary of operation
// - only digital signals pass; analog fixed
// - one input select register per peripheral
// - many inputs may share one pin
// - port read always returns pin level
// - input select: port and pin, defaults
// - per-pin output select; zero means latch
// - source codes decoded; reserved selects nothing
// - direction control rules unless peripheral overrides
// - lock clear at reset; writes free
// - lock set freezes every select register
// - lock changes only after 55, AA key
// - one-shot config: lock set once
// - without one-shot, lock toggles with key
// - power reset restores selects; nrst_i clears lock, por_i does not
// - writes while locked silently ignored
`timescale 1ns/100ps
`default_nettype none
module prl_routing_lock (
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  input  wire logic                          por_i,
  input  wire logic                          one_shot_lock_config_i,
  input  wire logic                          in_sel_we_i,
  input  wire logic [2:0]                    in_sel_idx_i,
  input  wire logic                          out_sel_we_i,
  input  wire logic [4:0]                    out_sel_idx_i,
  input  wire logic                          lock_reg_we_i,
  input  wire logic [prl_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic [prl_pkg::N_PINS-1:0]    pin_level_i,
  input  wire logic [prl_pkg::N_PINS-1:0]    pin_output_latch_i,
  input  wire logic [prl_pkg::N_PINS-1:0]    pin_direction_control_i,
  input  wire logic [prl_pkg::N_SRC-1:0]     periph_out_i,
  input  wire logic [prl_pkg::N_SRC-1:0]     periph_drive_req_i,
  input  wire logic [prl_pkg::N_SRC-1:0]     periph_drive_en_i,
  output logic [prl_pkg::N_IN_SEL-1:0]       periph_in_o,
  output logic [prl_pkg::N_PINS-1:0]         port_read_o,
  output logic [prl_pkg::N_PINS-1:0]         pin_out_o,
  output logic [prl_pkg::N_PINS-1:0]         pin_oe_o,
  output logic                               routing_locked_bit_o,
  output logic [prl_pkg::N_IN_SEL*6-1:0]     in_sel_o,
  output logic [prl_pkg::N_PINS*6-1:0]       out_sel_o
);
  import prl_pkg::*;

  logic [N_PINS-1:0]    pin_meta_ff;
  logic [N_PINS-1:0]    pin_sync_ff;
  logic [SEL_W-1:0]     in_sel_ff  [N_IN_SEL];
  logic [OSRC_W-1:0]    out_sel_ff [N_PINS];
  logic                 locked_ff;
  logic                 nxt_locked;
  logic                 once_set_ff;
  prl_key_t             key_ff;
  prl_key_t             nxt_key;
  logic                 any_we;
  logic                 sel_we;
  logic                 lock_only_we;
  logic                 lock_data;
  logic                 key_done;
  logic                 clear_allowed;
  logic                 sel_write_ok;
  logic [N_IN_SEL-1:0]  in_sel_hit;
  logic [N_PINS-1:0]    out_sel_hit;

  // pin levels come from outside: two flops before use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_ff <= '0;
    end else begin
      pin_meta_ff <= pin_level_i;
    end
  end

  // only this stage reads the first flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_sync_ff <= '0;
    end else begin
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign port_read_o = pin_sync_ff;

  assign sel_we        = in_sel_we_i | out_sel_we_i;
  assign any_we        = sel_we | lock_reg_we_i;
  // a lock write sharing its cycle with a select write counts as stray
  assign lock_only_we  = lock_reg_we_i & ~sel_we;
  assign lock_data     = wdata_i[LOCK_BIT_POS];
  assign key_done      = lock_only_we && (key_ff == KEY_ARMED);
  // one-shot: a clear is refused once the lock was set since reset
  assign clear_allowed = !(one_shot_lock_config_i && once_set_ff);

  // key progress: 55, then AA, then the lock write
  always_comb begin
    nxt_key = key_ff;
    if (any_we) begin
      nxt_key = KEY_IDLE;
      if (lock_only_we) begin
        case (key_ff)
          KEY_IDLE: begin
            if (wdata_i == KEY_FIRST) nxt_key = KEY_HALF;
          end
          KEY_HALF: begin
            if (wdata_i == KEY_SECOND) begin
              nxt_key = KEY_ARMED;
            end else if (wdata_i == KEY_FIRST) begin
              nxt_key = KEY_HALF;
            end
          end
          KEY_ARMED: begin
            nxt_key = KEY_IDLE;
          end
          default: begin
            nxt_key = KEY_IDLE;
          end
        endcase
      end
    end
  end

  // lock bit moves only on the write that completes the key
  always_comb begin
    nxt_locked = locked_ff;
    if (key_done) begin
      if (lock_data) begin
        nxt_locked = 1'b1;
      end else if (clear_allowed) begin
        nxt_locked = 1'b0;
      end
    end
  end

  // nrst_i clears the lock, por_i does not; selects do not see this reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_ff <= 1'b0;
    end else begin
      locked_ff <= nxt_locked;
    end
  end

  // a warm reset drops key progress too
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_ff <= KEY_IDLE;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // one-shot memory: once set, a clear is refused until reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      once_set_ff <= 1'b0;
    end else if (nxt_locked) begin
      once_set_ff <= 1'b1;
    end
  end

  assign routing_locked_bit_o = locked_ff;

  // selects take writes only while the lock bit is clear
  assign sel_write_ok = !locked_ff;

  // selects survive warm resets; only power reset (por_i, sync) restores them
  generate
    for (genvar gi = 0; gi < N_IN_SEL; gi++) begin : g_in
      assign in_sel_hit[gi] = in_sel_we_i && sel_write_ok && (in_sel_idx_i == 3'(gi));
      always_ff @(posedge clk_i) begin
        if (por_i) begin
          in_sel_ff[gi] <= IN_SEL_RESET[gi];
        end else if (in_sel_hit[gi]) begin
          in_sel_ff[gi] <= wdata_i[SEL_W-1:0];
        end
      end
      prl_in_mux u_mux (
        .pin_level_i (pin_sync_ff),
        .sel_i       (in_sel_ff[gi]),
        .level_o     (periph_in_o[gi])
      );
      assign in_sel_o[gi*6 +: 6] = in_sel_ff[gi];
    end

    for (genvar gp = 0; gp < N_PINS; gp++) begin : g_out
      logic              src_ok;
      logic              src_is_latch;
      logic              periph_owns;
      logic [OSRC_W-1:0] src_code;
      // indices 24..31 match no pin, so such writes fall away
      assign out_sel_hit[gp] = out_sel_we_i && sel_write_ok && (out_sel_idx_i == 5'(gp));
      always_ff @(posedge clk_i) begin
        if (por_i) begin
          out_sel_ff[gp] <= OSRC_RESET;
        end else if (out_sel_hit[gp]) begin
          out_sel_ff[gp] <= wdata_i[OSRC_W-1:0];
        end
      end
      assign src_code = out_sel_ff[gp];
      assign src_is_latch = (src_code == OSRC_LATCH);
      // reserved and out-of-range codes drive low and leave direction alone
      assign src_ok = !src_is_latch && (src_code <= OSRC_MAX) && OSRC_VALID[src_code];
      // a peripheral that runs the driver itself overrides direction control
      assign periph_owns = src_ok && periph_drive_req_i[src_code];

      always_comb begin
        pin_out_o[gp] = 1'b0;
        pin_oe_o[gp]  = !pin_direction_control_i[gp];
        if (src_is_latch) begin
          pin_out_o[gp] = pin_output_latch_i[gp];
        end else if (src_ok) begin
          pin_out_o[gp] = periph_out_i[src_code];
        end
        if (periph_owns) begin
          pin_oe_o[gp] = periph_drive_en_i[src_code];
        end
      end
      assign out_sel_o[gp*6 +: 6] = out_sel_ff[gp];
    end
  endgenerate
endmodule : prl_routing_lock
`default_nettype wire

// >>> verification/prl_rl_props.sv
`timescale 1ns/100ps
`default_nettype none
module prl_rl_props
  import prl_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         por_i,
  input wire logic         one_shot_lock_config_i,
  input wire logic         in_sel_we_i,
  input wire logic         out_sel_we_i,
  input wire logic         lock_reg_we_i,
  input wire logic         routing_locked_bit_o,
  input wire logic [2:0]   in_sel_idx_i,
  input wire logic [7:0]   wdata_i,
  input wire logic [23:0]  pin_output_latch_i,
  input wire logic [23:0]  pin_direction_control_i,
  input wire logic [23:0]  pin_out_o,
  input wire logic [23:0]  pin_oe_o,
  input wire logic [47:0]  in_sel_o,
  input wire logic [143:0] out_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic sel_we = in_sel_we_i | out_sel_we_i;
  wire logic lk_only = lock_reg_we_i & ~sel_we;
  wire logic quiet = ~sel_we & ~lock_reg_we_i;
  wire logic [5:0] wsel = wdata_i[5:0];
  AST_IN_LOCKED: assert property (routing_locked_bit_o && in_sel_we_i && !por_i
    |=> $stable(in_sel_o)) else $error("input select written while locked");
  AST_OUT_LOCKED: assert property (routing_locked_bit_o && out_sel_we_i && !por_i
    |=> $stable(out_sel_o)) else $error("output select written while locked");
  AST_LOCK_QUIET: assert property (!lock_reg_we_i |=> $stable(routing_locked_bit_o))
    else $error("lock bit moved without a lock write");
  AST_KEY_SET: assert property (lk_only && wdata_i == KEY_FIRST ##1 quiet ##1 lk_only
    && wdata_i == KEY_SECOND ##1 quiet ##1 lk_only && wdata_i[0] |=> routing_locked_bit_o)
    else $error("key sequence did not set lock");
  AST_ONE_SHOT: assert property (one_shot_lock_config_i && routing_locked_bit_o
    |=> routing_locked_bit_o) else $error("one-shot lock cleared");
  AST_STRAY: assert property (sel_we ##1 quiet ##1 lk_only && wdata_i == KEY_SECOND
    ##2 lk_only |=> $stable(routing_locked_bit_o)) else $error("aborted key changed lock");
  AST_POR: assert property (por_i |=> in_sel_o[5:0] == IN_SEL_RESET[0] && out_sel_o == '0)
    else $error("power reset defaults wrong");
  AST_SEL_WR: assert property (!routing_locked_bit_o && in_sel_we_i && in_sel_idx_i == 3'h0
    && !por_i |=> in_sel_o[5:0] == $past(wsel)) else $error("unlocked write lost");
  AST_LATCH: assert property (out_sel_o[5:0] == OSRC_LATCH |-> pin_out_o[0] ==
    pin_output_latch_i[0] && pin_oe_o[0] == !pin_direction_control_i[0]) else $error("latch path");
endmodule : prl_rl_props
bind prl_routing_lock prl_rl_props prl_rl_props_i (.*);
`default_nettype wire

// >>> verification/prl_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module prl_pin_model (
  input  wire logic [23:0] pin_out_i,
  input  wire logic [23:0] pin_oe_i,
  input  wire logic [23:0] ext_level_i,
  output logic      [23:0] pin_level_o
);
  // a driven pin reads back its own level, the rest follow the board
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_level_i);
endmodule : prl_pin_model
`default_nettype wire

// >>> verification/test_prl_routing_lock.sv
`timescale 1ns/100ps
`default_nettype none
module test_prl_routing_lock;
  import prl_pkg::*;
  logic clk_i = 0, nrst_i = 0, por_i = 1, cfg = 0, isw = 0, osw = 0, lkw = 0, lock;
  logic [4:0] idx = 0;
  logic [7:0] wd = 0, pin_in;
  logic [23:0] ext = 0, lat = 0, dir = '1, lvl, pout, poe, prd;
  logic [35:0] psrc = 0, preq = 0, pen = 0;
  logic [47:0] isel;
  logic [143:0] osel;
  int n_errors = 0, checks_done = 0;
  always #5 clk_i = ~clk_i;
  prl_routing_lock prl_routing_lock_i (.clk_i(clk_i), .nrst_i(nrst_i), .por_i(por_i),
    .one_shot_lock_config_i(cfg), .in_sel_we_i(isw), .in_sel_idx_i(idx[2:0]),
    .out_sel_we_i(osw), .out_sel_idx_i(idx), .lock_reg_we_i(lkw), .wdata_i(wd),
    .pin_level_i(lvl), .pin_output_latch_i(lat), .pin_direction_control_i(dir),
    .periph_out_i(psrc), .periph_drive_req_i(preq), .periph_drive_en_i(pen),
    .periph_in_o(pin_in), .port_read_o(prd), .pin_out_o(pout), .pin_oe_o(poe),
    .routing_locked_bit_o(lock), .in_sel_o(isel), .out_sel_o(osel));
  prl_pin_model prl_pin_model_i (.pin_out_i(pout), .pin_oe_i(poe), .ext_level_i(ext),
    .pin_level_o(lvl));
  // k: 0 input select, 1 output select, 2 lock register; idle cycle after each
  task automatic wr(input int k, input logic [4:0] i, input logic [7:0] d);
    @(posedge clk_i);
    #1 {isw, osw, lkw} = 3'b100 >> k;
    idx = i;
    wd = d;
    @(posedge clk_i);
    #1 {isw, osw, lkw} = 3'b000;
  endtask : wr
  task automatic key(input logic [7:0] d);
    wr(2, 0, KEY_FIRST);
    wr(2, 0, KEY_SECOND);
    wr(2, 0, d);
  endtask : key
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(posedge clk_i);
    #1 nrst_i = 1;
    @(posedge clk_i);
    #1 por_i = 0;
    chk(isel, {6'h11, 6'h05, 6'h14, 6'h15, 6'h04, 6'h05, 6'h02, 6'h02});
    chk(osel, 0);
    chk(lock, 0);
    $display("reset defaults done");
    wr(0, 0, 8'h0B);
    wr(0, 1, 8'h0B);
    wr(0, 4, 8'h2B);
    ext[11] = 1;
    repeat (3) @(posedge clk_i);
    #1 chk({pin_in[4], pin_in[1:0], prd[11]}, 4'b0111);
    preq[2] = 1;
    pen[2] = 1;
    wr(1, 1, 8'h02);
    chk(poe[1], 1);
    wr(0, 3, 8'h01);
    psrc[2] = 1;
    repeat (3) @(posedge clk_i);
    #1 chk({poe[1], pout[1], pin_in[3]}, 3'b111);
    lat[0] = 1;
    wr(1, 0, 8'h00);
    chk(pout[0], 1);
    dir[0] = 0;
    // reserved codes must leave the pin low with their own source high, out-of-range codes with every source high
    for (int c = 1; c < 64; c++) begin
      psrc = (c < 36) ? 36'h1 << c : '1;
      wr(1, 0, 8'(c));
      chk(pout[0], (c < 36) ? OSRC_VALID[c] : 1'b0);
    end
    $display("routing done");
    wr(2, 0, KEY_FIRST);
    wr(0, 2, 8'h00);
    wr(2, 0, KEY_SECOND);
    wr(2, 0, 8'h01);
    chk(lock, 0);
    key(8'h01);
    chk(lock, 1);
    wr(0, 0, 8'h00);
    wr(1, 0, 8'h00);
    chk({isel[5:0], osel[5:0]}, {6'h0B, 6'h3F});
    key(8'h00);
    chk(lock, 0);
    $display("lock key done");
    cfg = 1;
    key(8'h01);
    key(8'h00);
    chk(lock, 1);
    nrst_i = 0;
    #10 nrst_i = 1;
    chk({lock, isel[5:0]}, {1'b0, 6'h0B});
    key(8'h01);
    chk(lock, 1);
    key(8'h00);
    chk(lock, 1);
    $display("one-shot done");
    wrap_up();
  end
endmodule : test_prl_routing_lock
`default_nettype wire
